/* File: cft_cfg.svh */
// Register offsets, field positions, reset values and timing counts of the four-channel timer
`ifndef CFT_CFG_SVH
`define CFT_CFG_SVH
// Global control: bit 0..1 cascade pair enables (bits 2..3 stored, unused), bit 8..11 timer enables
`define CFT_GCTL_OFFSET     8'h00
// Per-timer block: base + 16 * timer index
`define CFT_TMR_BASE        8'h10
`define CFT_TMR_STRIDE      8'h10
`define CFT_MODE_OFFSET     4'h0
`define CFT_REF_OFFSET      4'h4
`define CFT_CNT_OFFSET      4'h8
`define CFT_CAP_OFFSET      4'hc
`define CFT_STAT_OFFSET     8'h50
`define CFT_MASK_OFFSET     8'h54
// Mode fields
`define CFT_MODE_SRC_LSB    0
`define CFT_MODE_EDGE_LSB   2
`define CFT_MODE_TOGGLE_BIT 4
`define CFT_MODE_GATE_BIT   5
`define CFT_MODE_RESTART_BIT 6
`define CFT_MODE_RESET      8'h00
`define CFT_REF_RESET       16'hffff
`define CFT_PRESCALE        16
`define CFT_PRESCALE_W      4
`endif

/* File: cft_pkg.sv */
// Types of the four-channel timer
package cft_pkg;
    typedef enum logic [1:0] {SRC_CASCADE, SRC_SYSCLK, SRC_DIV16, SRC_PIN} cft_src_e;
    typedef enum logic [1:0] {CAP_OFF, CAP_RISE, CAP_FALL, CAP_BOTH} cft_edge_e;
    typedef logic [15:0] cft_count_t;
endpackage : cft_pkg

/* File: cft_channel.sv */
// One 16-bit timer channel: counter, reference compare, capture, output pin
`timescale 1ns/1ns
`include "cft_cfg.svh"
module cft_channel
(
    // Clock and reset
    input  wire logic           mclk,
    input  wire logic           rstSyncN,
    // Configuration
    input  wire logic           enable,
    input  wire cft_pkg::cft_src_e  srcSel,
    input  wire cft_pkg::cft_edge_e edgeSel,
    input  wire logic           toggleMode,
    input  wire logic           gateMode,
    input  wire logic           restartMode,
    input  wire cft_pkg::cft_count_t refValue,
    input  wire logic           cntWrite,
    input  wire cft_pkg::cft_count_t cntWriteData,
    // Count sources, already synchronised
    input  wire logic           cascadeTick,
    input  wire logic           div16Tick,
    input  wire logic           pinLevel,
    input  wire logic           gateLevelN,
    // Results
    output cft_pkg::cft_count_t countValue,
    output cft_pkg::cft_count_t captureValue,
    output logic                refEvent,
    output logic                capEvent,
    output logic                timerOut
);
    import cft_pkg::*;

    cft_count_t cnt_reg, cnt_next, cap_reg, cap_next;
    logic pin_reg, gate_reg, out_reg, out_next, ref_reg, ref_next, capEv_reg, capEv_next;
    logic pinRise, pinFall, gateFall, tick, capHit;

    always_comb
    begin
        pinRise  = pinLevel & ~pin_reg;
        pinFall  = ~pinLevel & pin_reg;
        gateFall = ~gateLevelN & gate_reg;
        unique case (srcSel)                                       // R1
            SRC_CASCADE: tick = cascadeTick;
            SRC_SYSCLK:  tick = 1'b1;
            SRC_DIV16:   tick = div16Tick;
            SRC_PIN:     tick = pinRise;
        endcase
        // Gated timers count only while their gate pin is held low
        if (gateMode && gateLevelN)                                // R7
            tick = 1'b0;
        unique case (edgeSel)                                      // R3
            CAP_OFF:  capHit = 1'b0;
            CAP_RISE: capHit = pinRise;
            CAP_FALL: capHit = pinFall;
            CAP_BOTH: capHit = pinRise | pinFall;
        endcase
        cnt_next   = cnt_reg;
        cap_next   = cap_reg;
        out_next   = out_reg;
        ref_next   = 1'b0;
        capEv_next = 1'b0;
        if (!enable)
        begin
            out_next = 1'b1;
        end
        else
        begin
            if (toggleMode == 1'b0)
                out_next = 1'b1;
            if (capHit)
            begin
                cap_next   = cnt_reg;
                capEv_next = 1'b1;
            end
            if (restartMode && gateFall)                           // R7
                cnt_next = '0;
            else if (tick)
            begin
                if (cnt_reg == refValue)                           // R4
                begin
                    cnt_next = '0;                                 // R8
                    ref_next = 1'b1;
                    out_next = toggleMode ? ~out_reg : 1'b0;       // R5
                end
                else
                    cnt_next = cnt_reg + 16'h0001;
            end
        end
        if (cntWrite)
            cnt_next = cntWriteData;
    end

    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            cnt_reg   <= '0;
            cap_reg   <= '0;
            pin_reg   <= 1'b0;
            gate_reg  <= 1'b1;
            out_reg   <= 1'b1;
            ref_reg   <= 1'b0;
            capEv_reg <= 1'b0;
        end
        else
        begin
            cnt_reg   <= cnt_next;
            cap_reg   <= cap_next;
            pin_reg   <= pinLevel;
            gate_reg  <= gateLevelN;
            out_reg   <= out_next;
            ref_reg   <= ref_next;
            capEv_reg <= capEv_next;
        end
    end

    assign countValue   = cnt_reg;
    assign captureValue = cap_reg;
    assign refEvent     = ref_reg;
    assign capEvent     = capEv_reg;
    assign timerOut     = out_reg;
endmodule : cft_channel

/* File: cft_timer.sv */
// Cascadable four-channel timer with AXI4-Lite register access
// Behaviour
// R1: Each timer counts other timer, system clock, clock/16, or its input pin.
// R2: Four timer input pins, one per timer, for counting or capture.
// R3: Capture triggers on rising, falling or both edges, per timer.
// R4: Each timer signals its output pin when counter reaches reference.
// R5: Reference output is an active-low pulse or a toggle of the level.
// R6: Timer output chains into the next timer, forming a 32-bit timer.
// R7: Gate pin one serves timers 1-2, gate pin two serves 3-4; gate/restart.
// R8: On reaching reference the counter clears and keeps counting.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "cft_cfg.svh"
module cft_timer
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Timer pins
    input  wire logic [3:0]  timerInputs,
    input  wire logic        gatePinLowPairN,
    input  wire logic        gatePinHighPairN,
    output logic [3:0]       timerOutputs,
    // Interrupt
    output logic             irq
);
    import cft_pkg::*;

    logic rstMeta, rstSyncN;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end
        else
        begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // Pin synchronisers: four inputs and two gates
    logic [5:0] pinMeta, pinSync;
    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            pinMeta <= 6'b11_0000;
            pinSync <= 6'b11_0000;
        end
        else
        begin
            pinMeta <= {gatePinHighPairN, gatePinLowPairN, timerInputs};   // R2
            pinSync <= pinMeta;
        end
    end

    // Shared divide-by-16 prescaler
    logic [`CFT_PRESCALE_W-1:0] pre_reg, pre_next;
    logic div16Tick;
    always_comb
    begin
        pre_next  = pre_reg + 4'h1;
        div16Tick = (pre_reg == 4'(`CFT_PRESCALE - 1));
    end

    // Registers
    logic [3:0]  cascade_reg, cascade_next, enable_reg, enable_next;
    logic [7:0]  mode_reg [4];
    logic [7:0]  mode_next [4];
    cft_count_t  ref_reg [4];
    cft_count_t  ref_next [4];
    logic [7:0]  stat_reg, stat_next, mask_reg, mask_next;
    logic [3:0]  cntWrite;
    cft_count_t  countValue [4];
    cft_count_t  captureValue [4];
    logic [3:0]  refEvent, capEvent, chanOut;

    // AXI state
    logic        awHeld_reg, awHeld_next, wHeld_reg, wHeld_next, bvalid_reg, bvalid_next;
    logic        rvalid_reg, rvalid_next;
    logic [7:0]  awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic        doWrite, doRead;
    logic [1:0]  wIdx, rIdx;

    assign s_axi_awready = ~awHeld_reg & ~bvalid_reg;
    assign s_axi_wready  = ~wHeld_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign doRead        = s_axi_arvalid & ~rvalid_reg;

    always_comb
    begin
        awHeld_next = awHeld_reg;
        wHeld_next  = wHeld_reg;
        awaddr_next = awaddr_reg;
        wdata_next  = wdata_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            awHeld_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wHeld_next = 1'b1;
            // Byte lanes above the low half are ignored: all fields fit in 16 bits
            wdata_next = {16'h0000,
                          s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                          s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
        end
        doWrite = awHeld_reg & wHeld_reg & ~bvalid_reg;
        wIdx    = 2'(awaddr_reg[7:4] - 4'h1);
        if (doWrite)
        begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = 2'b00;
            if (awaddr_reg[1:0] != 2'b00 || awaddr_reg > `CFT_MASK_OFFSET)
                bresp_next = 2'b10;
        end
        else if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
    end

    always_comb
    begin
        cascade_next = cascade_reg;
        enable_next  = enable_reg;
        mask_next    = mask_reg;
        cntWrite     = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            mode_next[i] = mode_reg[i];
            ref_next[i]  = ref_reg[i];
        end
        if (doWrite && bresp_next == 2'b00)
        begin
            if (awaddr_reg == `CFT_GCTL_OFFSET)
            begin
                cascade_next = wdata_reg[3:0];
                enable_next  = wdata_reg[11:8];
            end
            else if (awaddr_reg == `CFT_MASK_OFFSET)
                mask_next = wdata_reg[7:0];
            else if (awaddr_reg >= `CFT_TMR_BASE && awaddr_reg < `CFT_STAT_OFFSET)
            begin
                unique case (awaddr_reg[3:0])
                    `CFT_MODE_OFFSET: mode_next[wIdx] = wdata_reg[7:0];
                    `CFT_REF_OFFSET:  ref_next[wIdx]  = wdata_reg[15:0];
                    `CFT_CNT_OFFSET:  cntWrite[wIdx]  = 1'b1;
                    default:          ;
                endcase
            end
        end
    end

    // Read path; reading status clears it, but new events in the same cycle stay set
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        stat_next   = stat_reg;
        rIdx        = 2'(s_axi_araddr[7:4] - 4'h1);
        if (doRead)
        begin
            rvalid_next = 1'b1;
            rresp_next  = 2'b00;
            rdata_next  = 32'h0000_0000;
            if (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > `CFT_MASK_OFFSET)
                rresp_next = 2'b10;
            else if (s_axi_araddr == `CFT_GCTL_OFFSET)
                rdata_next = {20'h0_0000, enable_reg, 4'h0, cascade_reg};
            else if (s_axi_araddr == `CFT_STAT_OFFSET)
            begin
                rdata_next = {24'h00_0000, stat_reg};
                stat_next  = 8'h00;
            end
            else if (s_axi_araddr == `CFT_MASK_OFFSET)
                rdata_next = {24'h00_0000, mask_reg};
            else if (s_axi_araddr >= `CFT_TMR_BASE)
            begin
                unique case (s_axi_araddr[3:0])
                    `CFT_MODE_OFFSET: rdata_next = {24'h00_0000, mode_reg[rIdx]};
                    `CFT_REF_OFFSET:  rdata_next = {16'h0000, ref_reg[rIdx]};
                    `CFT_CNT_OFFSET:  rdata_next = {16'h0000, countValue[rIdx]};
                    `CFT_CAP_OFFSET:  rdata_next = {16'h0000, captureValue[rIdx]};
                    default:          rdata_next = 32'h0000_0000;
                endcase
            end
        end
        else if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
        stat_next = stat_next | {capEvent, refEvent};
    end

    always_ff @(posedge mclk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            pre_reg     <= '0;
            cascade_reg <= 4'h0;
            enable_reg  <= 4'h0;
            stat_reg    <= 8'h00;
            mask_reg    <= 8'h00;
            awHeld_reg  <= 1'b0;
            wHeld_reg   <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= 2'b00;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= 2'b00;
            for (int i = 0; i < 4; i++)
            begin
                mode_reg[i] <= `CFT_MODE_RESET;
                ref_reg[i]  <= `CFT_REF_RESET;
            end
        end
        else
        begin
            pre_reg     <= pre_next;
            cascade_reg <= cascade_next;
            enable_reg  <= enable_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            awHeld_reg  <= awHeld_next;
            wHeld_reg   <= wHeld_next;
            awaddr_reg  <= awaddr_next;
            wdata_reg   <= wdata_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            for (int i = 0; i < 4; i++)
            begin
                mode_reg[i] <= mode_next[i];
                ref_reg[i]  <= ref_next[i];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gChan
            // Odd timer takes the even timer's reference event when the pair is cascaded
            logic cascadeTick;
            if (g % 2 == 1)
                assign cascadeTick = refEvent[g-1] & cascade_reg[g/2];          // R6
            else
                assign cascadeTick = refEvent[(g+3)%4];
            cft_channel u_cft_channel
            (
                .mclk         (mclk),
                .rstSyncN     (rstSyncN),
                .enable       (enable_reg[g]),
                .srcSel       (cft_src_e'(mode_reg[g][`CFT_MODE_SRC_LSB +: 2])),
                .edgeSel      (cft_edge_e'(mode_reg[g][`CFT_MODE_EDGE_LSB +: 2])),
                .toggleMode   (mode_reg[g][`CFT_MODE_TOGGLE_BIT]),
                .gateMode     (mode_reg[g][`CFT_MODE_GATE_BIT]),
                .restartMode  (mode_reg[g][`CFT_MODE_RESTART_BIT]),
                .refValue     (ref_reg[g]),
                .cntWrite     (cntWrite[g]),
                .cntWriteData (wdata_reg[15:0]),
                .cascadeTick  (cascadeTick),
                .div16Tick    (div16Tick),
                .pinLevel     (pinSync[g]),
                .gateLevelN   (pinSync[4 + g/2]),                               // R7
                .countValue   (countValue[g]),
                .captureValue (captureValue[g]),
                .refEvent     (refEvent[g]),
                .capEvent     (capEvent[g]),
                .timerOut     (chanOut[g])
            );
        end
    endgenerate

    assign timerOutputs  = chanOut;                                             // R4
    assign irq           = |(stat_reg & mask_reg);
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
endmodule : cft_timer

/* File: cft_timer_end.sv */
// No logic here

/* File: cft_timer_sva.sv */
// Bus-timing and pin-idle checks of the four-channel timer
`timescale 1ns/1ns
module cft_timer_sva
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rstn,
    // AXI4-Lite
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Pins
    input wire logic [3:0]  timerInputs,
    input wire logic        gatePinLowPairN,
    input wire logic        gatePinHighPairN,
    input wire logic [3:0]  timerOutputs,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence arTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence bothTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence arBad;
        arTake ##0 (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > 8'h54);
    endsequence
    sequence awBad;
        bothTake ##0 (s_axi_awaddr[1:0] != 2'b00 || s_axi_awaddr > 8'h54);
    endsequence
    chk_rd_answer: assert property (arTake |=> s_axi_rvalid)
        else $error("read answer late");
    chk_rd_slverr: assert property (arBad |=> s_axi_rresp == 2'b10)
        else $error("bad read address not refused");
    chk_wr_answer: assert property (bothTake |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_wr_slverr: assert property (awBad |-> ##2 s_axi_bresp == 2'b10)
        else $error("bad write address not refused");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    chk_out_idle: assert property ($rose(rstn) |-> timerOutputs == 4'hf)
        else $error("timer outputs not idle high");
endmodule : cft_timer_sva
bind cft_timer cft_timer_sva u_cft_timer_sva (.*);

/* File: cft_pin_source.sv */
// Far-side pin model: timer input pulses and gate levels
`timescale 1ns/1ns
module cft_pin_source
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Requests from the bench
    input  wire logic [3:0] pulseReq,
    input  wire logic       gateLowReqN,
    input  wire logic       gateHighReqN,
    // Pins
    output logic [3:0]      timerInputs,
    output logic            gatePinLowPairN,
    output logic            gatePinHighPairN
);
    logic [2:0] left [4];
    always_ff @(posedge mclk or negedge rstn)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!rstn)
                left[i] <= 3'h0;
            else if (pulseReq[i])
                left[i] <= 3'h4;
            else if (left[i] != 3'h0)
                left[i] <= left[i] - 3'h1;
        end
        // Gates idle inactive so no gated timer counts by accident
        gatePinLowPairN  <= rstn ? gateLowReqN : 1'b1;
        gatePinHighPairN <= rstn ? gateHighReqN : 1'b1;
    end
    // Each pin feeds only its own timer, high four cycles per request
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            timerInputs[i] = (left[i] != 3'h0);
    end
endmodule : cft_pin_source

/* File: tb_cft_timer.sv */
// Self-checking bench of the four-channel timer
`timescale 1ns/1ns
module tb_cft_timer;
    logic        mclk, rstn, irq, gatePinLowPairN, gatePinHighPairN, gateLowReqN, gateHighReqN;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, c1, c3;
    logic [3:0]  s_axi_wstrb, timerInputs, timerOutputs, pulseReq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          fails, samples_checked;
    cft_timer u_cft_timer (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timerInputs, .gatePinLowPairN,
        .gatePinHighPairN, .timerOutputs, .irq);
    cft_pin_source u_cft_pin_source (.mclk, .rstn, .pulseReq, .gateLowReqN, .gateHighReqN,
        .timerInputs, .gatePinLowPairN, .gatePinHighPairN);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic cycles(input int k);
        repeat (k) @(posedge mclk);
    endtask : cycles
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw, tb;
        pa = 1'b1;
        pw = 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (pa || pw)
        begin
            @(negedge mclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge mclk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge mclk);
            tb = s_axi_bvalid;
            rr = s_axi_bresp;
            @(posedge mclk);
        end while (!tb);
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        logic t;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(negedge mclk);
            t = s_axi_arready;
            @(posedge mclk);
        end while (!t);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(negedge mclk);
            t = s_axi_rvalid;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge mclk);
        end while (!t);
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic cfg(input logic [3:0] n, input logic [7:0] mode, input logic [15:0] refv);
        axi_wr({n, 4'h0}, {24'h00_0000, mode});
        axi_wr({n, 4'h4}, {16'h0000, refv});
        // A held count above a new reference would need a full wrap
        axi_wr({n, 4'h8}, 32'h0);
    endtask : cfg
    // Fall-to-fall period and low width of one output, in clock cycles
    task automatic measure(input int i, input int per, input int low);
        int n, lw;
        n = 0;
        lw = 0;
        do @(negedge mclk); while (timerOutputs[i] !== 1'b1);
        do @(negedge mclk); while (timerOutputs[i] !== 1'b0);
        do
        begin
            @(negedge mclk);
            n++;
            lw += (timerOutputs[i] === 1'b0) && (n == lw + 1);
        end while (timerOutputs[i] !== 1'b0 || n == lw);
        check(lw + 1, low);
        check(n, per);
        @(posedge mclk);
        axi_wr(8'h00, 32'h0000_0000);
    endtask : measure
    task automatic t_map;
        axi_rd(8'h14);
        check(rd, 32'h0000_ffff);
        axi_rd(8'h10);
        check(rd, 32'h0000_0000);
        axi_rd(8'h04);
        check({rd[29:0], rr}, 32'h0000_0000);
        axi_rd(8'h58);
        check(rr, 2'b10);
        axi_wr(8'h12, 32'h0000_0001);
        check(rr, 2'b10);
    endtask : t_map
    task automatic t_capture;
        cfg(3, 8'h05, 16'hffff);
        cfg(4, 8'h09, 16'hffff);
        axi_rd(8'h50);
        axi_wr(8'h00, 32'h0000_0c00);
        cycles(10);
        pulseReq <= 4'b1100;
        @(posedge mclk);
        pulseReq <= 4'b0000;
        cycles(12);
        axi_wr(8'h00, 32'h0000_0000);
        axi_rd(8'h3c);
        c3 = rd;
        axi_rd(8'h4c);
        check(rd - c3, 32'h0000_0004);
        axi_rd(8'h50);
        check(rd & 32'h0000_00c0, 32'h0000_00c0);
    endtask : t_capture
    task automatic t_pin;
        cfg(4, 8'h03, 16'hffff);
        axi_wr(8'h00, 32'h0000_0800);
        for (int k = 0; k < 4; k++)
        begin
            pulseReq <= (k == 2) ? 4'b0100 : 4'b1000;
            @(posedge mclk);
            pulseReq <= 4'b0000;
            cycles(10);
        end
        axi_wr(8'h00, 32'h0000_0000);
        axi_rd(8'h48);
        check(rd, 32'h0000_0003);
    endtask : t_pin
    task automatic t_gate;
        cfg(1, 8'h21, 16'hffff);
        cfg(3, 8'h21, 16'hffff);
        for (int k = 0; k < 2; k++)
        begin
            gateLowReqN  <= (k == 1);
            gateHighReqN <= (k == 0);
            axi_wr(8'h00, 32'h0000_0500);
            axi_rd(8'h18);
            c1 = rd;
            axi_rd(8'h38);
            c3 = rd;
            cycles(20);
            axi_rd(8'h18);
            check(32'(rd != c1), 32'(k == 0));
            axi_rd(8'h38);
            check(32'(rd != c3), 32'(k == 1));
        end
        axi_wr(8'h00, 32'h0000_0000);
    endtask : t_gate
    task automatic t_irq;
        cfg(1, 8'h01, 16'h0003);
        axi_wr(8'h54, 32'h0000_0000);
        axi_rd(8'h50);
        axi_wr(8'h00, 32'h0000_0100);
        cycles(20);
        axi_wr(8'h00, 32'h0000_0000);
        check(irq, 1'b0);
        axi_wr(8'h54, 32'h0000_0001);
        cycles(2);
        check(irq, 1'b1);
        axi_rd(8'h50);
        check(rd & 32'h0000_0001, 32'h0000_0001);
        cycles(2);
        check(irq, 1'b0);
        axi_rd(8'h50);
        check(rd, 32'h0000_0000);
    endtask : t_irq
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        #400000;
        fails++;
        complete_run;
    end
    initial
    begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pulseReq} = 52'h0;
        s_axi_wstrb = 4'hf;
        {gateLowReqN, gateHighReqN} = 2'b11;
        fails = 0;
        samples_checked = 0;
        cycles(10);
        rstn <= 1'b1;
        cycles(5);
        t_map;
        t_capture;
        cfg(1, 8'h01, 16'h0003);
        axi_wr(8'h00, 32'h0000_0100);
        measure(0, 4, 1);
        cfg(2, 8'h11, 16'h0002);
        axi_wr(8'h00, 32'h0000_0200);
        measure(1, 6, 3);
        cfg(3, 8'h02, 16'h0000);
        axi_wr(8'h00, 32'h0000_0400);
        measure(2, 16, 1);
        cfg(1, 8'h01, 16'h0001);
        cfg(2, 8'h00, 16'h0002);
        axi_wr(8'h00, 32'h0000_0301);
        measure(1, 6, 1);
        t_pin;
        t_gate;
        t_irq;
        complete_run;
    end
endmodule : tb_cft_timer
